// ==== common/pwu_pkg.sv ====
// Constants, field layout and carrier types for the periodic wakeup timer and trim block.
// Assumes a 10 MHz register clock and word-indexed registers on an AXI4-Lite slave.
// Behaviour
// - Rate high and low bytes always readable; writes ignored while feature enable set.
// - Autonomous clock source: period is 2*(rate+1)*2 autonomous clock periods.
// - Bus clock source: period is 2*(rate+1) bus clock periods, 2 to 131072.
// - Autonomous source: first timeout delayed one to two autonomous cycles by gate release.
// - Factory test register always readable; written only in special mode.
// - Temperature trim loaded from nonvolatile value at reset release; then freely read/written.
// - Temperature trim bit 7 enables offset; when clear, offset field has no effect.
// - When enabled, bits 3:0 select offset, binary weighted.
// - Both oscillator trim registers loaded from nonvolatile value at reset release.
// - Oscillator trim always readable; writes take effect only while protection is clear.
// - Oscillator trim write while PLL select set and protection clear clears lock and oscillator-up status.
// - Frequency trim bits 9:6 form the coarse trim.
// - Frequency trim bits 5:0 form the fine trim.
// - Tempco codes 00000 and 10000 both give nominal, uncompensated coefficient.
// - Setting feature enable starts the timer; clearing it stops the periodic function.
// - Clock select: 0 autonomous, 1 bus; writable only while enable clear.
// - Timeout sets flag; cleared by writing one; interrupt while flag and enable set.
package pwu_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_CTRL = 6'h12;
   localparam logic [5:0] IDX_RATE_HIGH = 6'h14;
   localparam logic [5:0] IDX_RATE_LOW = 6'h15;
   localparam logic [5:0] IDX_FACTORY_TEST = 6'h16;
   localparam logic [5:0] IDX_TEMP_TRIM = 6'h17;
   localparam logic [5:0] IDX_OSC_TRIM_HIGH = 6'h18;
   localparam logic [5:0] IDX_OSC_TRIM_LOW = 6'h19;
   localparam logic [5:0] IDX_INT_STATUS = 6'h1C;
   localparam logic [5:0] IDX_INT_MASK = 6'h1D;
   // Field positions
   localparam int CTRL_CLKSEL_BIT = 7;
   localparam int CTRL_ENABLE_BIT = 2;
   localparam int INT_TIMEOUT_BIT = 0;
   localparam int TEMP_OE_BIT = 7;
   localparam int TRIMH_TC_LSB = 3;
   // Reset values
   localparam logic [15:0] RATE_RESET = 16'h0000;
   localparam logic [7:0] TEST_RESET = 8'h00;
   // Gate edge count, counter width and bus response codes
   localparam int GATE_RELEASE_EDGES = 2;
   localparam int CNT_W = 19;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      T_IDLE = 3'b001,
      T_GATE = 3'b010,
      T_RUN = 3'b100
   } timer_state_e;

   typedef struct packed {
      logic offset_enable;
      logic [3:0] offset;
   } temp_trim_s;

   typedef struct packed {
      logic tc_comp_on;
      logic [4:0] tempco;
      logic [3:0] coarse;
      logic [5:0] fine;
   } osc_trim_s;
endpackage

// ==== design/pin_sync3.sv ====
// Three-stage synchroniser with agreement filter for an asynchronous level.
// Assumes the input may change at any time relative to ref_clk_i.
`timescale 1ns/1ps
module pin_sync3 (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic async_i,
   output logic level_o
);
   logic meta_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_o <= 1'b0;
      end else if (clk_en_i) begin
         meta_reg <= async_i;
         s2_reg <= meta_reg;
         s3_reg <= s2_reg;
         // A change counts only once two late stages agree
         if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
         end
      end
   end
endmodule

// ==== design/period_counter.sv ====
// Reloading period counter: pulses once every term ticks while running.
// Assumes term is stable while run is high.
`timescale 1ns/1ps
module period_counter #(
   parameter int WIDTH = 19
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [WIDTH-1:0] term_i,
   output logic timeout_o
);
   logic [WIDTH-1:0] cnt_reg;
   logic last;

   assign last = (cnt_reg == term_i - WIDTH'(1));

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_reg <= '0;
         timeout_o <= 1'b0;
      end else if (clk_en_i) begin
         timeout_o <= 1'b0;
         if (!run_i) begin
            cnt_reg <= '0;
         end else if (tick_i) begin
            if (last) begin
               cnt_reg <= '0;
               timeout_o <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + WIDTH'(1);
            end
         end
      end
   end

   property p_restart;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && run_i && tick_i && last) |=> (cnt_reg == '0) && timeout_o;
   endproperty
   a_restart: assert property (p_restart) else $error("counter did not restart");
endmodule

// ==== design/periodic_wakeup_top.sv ====
// Periodic wakeup timer with rate, factory test and trim registers on AXI4-Lite.
// Assumes special mode, protection, PLL select and nonvolatile trim come from same-clock logic;
// the autonomous clock arrives as an asynchronous pin.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module periodic_wakeup_top (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic [pwu_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [pwu_pkg::DATA_W-1:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [pwu_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [pwu_pkg::DATA_W-1:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic aclk_pin_i,
   input wire logic special_mode_i,
   input wire logic register_protect_i,
   input wire logic pll_clock_select_i,
   input wire logic [7:0] nvm_temp_trim_i,
   input wire logic [15:0] nvm_osc_trim_i,
   output logic irq_o,
   output logic periodic_timeout_o,
   output logic lock_osc_clear_o,
   output pwu_pkg::temp_trim_s temp_trim_o,
   output pwu_pkg::osc_trim_s osc_trim_o
);
   import pwu_pkg::*;

   logic aw_hold_reg;
   logic w_hold_reg;
   logic [5:0] aw_idx_reg;
   logic [7:0] wbyte_reg;
   logic wlane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic do_write;
   logic ar_take;
   logic [5:0] ar_idx;
   logic wr_ok;

   logic feature_enable_reg;
   logic clock_select_reg;
   logic [15:0] rate_reg;
   logic [7:0] test_reg;
   logic temp_oe_reg;
   logic [3:0] temp_trim_reg;
   logic [7:0] osc_high_reg;
   logic [7:0] osc_low_reg;
   logic timeout_flag_reg;
   logic irq_enable_reg;
   logic load_pending_reg;

   timer_state_e state_reg;
   logic [1:0] gate_cnt_reg;
   logic aclk_level;
   logic aclk_prev_reg;
   logic aclk_rise;
   logic tick;
   logic [16:0] rate_p1;
   logic [CNT_W-1:0] term;
   logic timeout;
   logic [CNT_W-1:0] seen_reg;

   logic wr_ctrl;
   logic wr_rate_hi;
   logic wr_rate_lo;
   logic wr_test;
   logic wr_temp;
   logic wr_osc;
   logic wr_status;
   logic wr_mask;

   // Write channel: address and data taken in either order, one write outstanding
   assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready_o = !w_hold_reg && !bvalid_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = !rvalid_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign ar_take = s_axi_arvalid_i && !rvalid_reg;
   assign ar_idx = s_axi_araddr_i[7:2];

   // Only byte lane 0 carries register data
   assign wr_ok = do_write && wlane_reg;
   assign wr_ctrl = wr_ok && (aw_idx_reg == IDX_CTRL);
   assign wr_rate_hi = wr_ok && (aw_idx_reg == IDX_RATE_HIGH);
   assign wr_rate_lo = wr_ok && (aw_idx_reg == IDX_RATE_LOW);
   assign wr_test = wr_ok && (aw_idx_reg == IDX_FACTORY_TEST);
   assign wr_temp = wr_ok && (aw_idx_reg == IDX_TEMP_TRIM);
   assign wr_osc = wr_ok && ((aw_idx_reg == IDX_OSC_TRIM_HIGH) ||
                             (aw_idx_reg == IDX_OSC_TRIM_LOW));
   assign wr_status = wr_ok && (aw_idx_reg == IDX_INT_STATUS);
   assign wr_mask = wr_ok && (aw_idx_reg == IDX_INT_MASK);

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx == IDX_CTRL) || (idx == IDX_RATE_HIGH) || (idx == IDX_RATE_LOW) ||
               (idx == IDX_FACTORY_TEST) || (idx == IDX_TEMP_TRIM) ||
               (idx == IDX_OSC_TRIM_HIGH) || (idx == IDX_OSC_TRIM_LOW) ||
               (idx == IDX_INT_STATUS) || (idx == IDX_INT_MASK);
   endfunction

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_idx_reg <= '0;
         wbyte_reg <= '0;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (clk_en_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr_i[7:2];
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_reg <= 1'b1;
            wbyte_reg <= s_axi_wdata_i[7:0];
            wlane_reg <= s_axi_wstrb_i[0];
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en_i) begin
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= 32'h0000_0000;
            unique case (ar_idx)
               IDX_CTRL: begin
                  rdata_reg[CTRL_CLKSEL_BIT] <= clock_select_reg;
                  rdata_reg[CTRL_ENABLE_BIT] <= feature_enable_reg;
               end
               IDX_RATE_HIGH: rdata_reg[7:0] <= rate_reg[15:8];
               IDX_RATE_LOW: rdata_reg[7:0] <= rate_reg[7:0];
               IDX_FACTORY_TEST: rdata_reg[7:0] <= test_reg;
               IDX_TEMP_TRIM: rdata_reg[7:0] <= {temp_oe_reg, 3'h0, temp_trim_reg};
               IDX_OSC_TRIM_HIGH: rdata_reg[7:0] <= osc_high_reg;
               IDX_OSC_TRIM_LOW: rdata_reg[7:0] <= osc_low_reg;
               IDX_INT_STATUS: rdata_reg[INT_TIMEOUT_BIT] <= timeout_flag_reg;
               IDX_INT_MASK: rdata_reg[INT_TIMEOUT_BIT] <= irq_enable_reg;
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Control: select may not change in the same write that sets enable
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         feature_enable_reg <= 1'b0;
         clock_select_reg <= 1'b0;
      end else if (clk_en_i && wr_ctrl) begin
         feature_enable_reg <= wbyte_reg[CTRL_ENABLE_BIT];
         if (!feature_enable_reg && !wbyte_reg[CTRL_ENABLE_BIT]) begin
            clock_select_reg <= wbyte_reg[CTRL_CLKSEL_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rate_reg <= RATE_RESET;
      end else if (clk_en_i && !feature_enable_reg) begin
         if (wr_rate_hi) begin
            rate_reg[15:8] <= wbyte_reg;
         end
         if (wr_rate_lo) begin
            rate_reg[7:0] <= wbyte_reg;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         test_reg <= TEST_RESET;
      end else if (clk_en_i && wr_test && special_mode_i) begin
         test_reg <= wbyte_reg;
      end
   end

   // Trim: nonvolatile values caught on the first enabled edge after reset release
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         load_pending_reg <= 1'b1;
         temp_oe_reg <= 1'b0;
         temp_trim_reg <= '0;
         osc_high_reg <= '0;
         osc_low_reg <= '0;
      end else if (clk_en_i) begin
         if (load_pending_reg) begin
            load_pending_reg <= 1'b0;
            temp_oe_reg <= nvm_temp_trim_i[TEMP_OE_BIT];
            temp_trim_reg <= nvm_temp_trim_i[3:0];
            osc_high_reg <= nvm_osc_trim_i[15:8];
            osc_low_reg <= nvm_osc_trim_i[7:0];
         end else begin
            if (wr_temp) begin
               temp_oe_reg <= wbyte_reg[TEMP_OE_BIT];
               temp_trim_reg <= wbyte_reg[3:0];
            end
            if (wr_osc && !register_protect_i) begin
               if (aw_idx_reg == IDX_OSC_TRIM_HIGH) begin
                  osc_high_reg <= wbyte_reg & 8'hFB;
               end else begin
                  osc_low_reg <= wbyte_reg;
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lock_osc_clear_o <= 1'b0;
      end else if (clk_en_i) begin
         lock_osc_clear_o <= wr_osc && !register_protect_i && pll_clock_select_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         temp_trim_o <= '0;
         osc_trim_o <= '0;
      end else if (clk_en_i) begin
         temp_trim_o.offset_enable <= temp_oe_reg;
         temp_trim_o.offset <= temp_oe_reg ? temp_trim_reg : 4'h0;
         osc_trim_o.tempco <= osc_high_reg[7:TRIMH_TC_LSB];
         osc_trim_o.tc_comp_on <= (osc_high_reg[6:TRIMH_TC_LSB] != 4'h0);
         osc_trim_o.coarse <= {osc_high_reg[1:0], osc_low_reg[7:6]};
         osc_trim_o.fine <= osc_low_reg[5:0];
      end
   end

   // Flag set wins over a simultaneous clear
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timeout_flag_reg <= 1'b0;
         irq_enable_reg <= 1'b0;
      end else if (clk_en_i) begin
         if (timeout) begin
            timeout_flag_reg <= 1'b1;
         end else if (wr_status && wbyte_reg[INT_TIMEOUT_BIT]) begin
            timeout_flag_reg <= 1'b0;
         end
         if (wr_mask) begin
            irq_enable_reg <= wbyte_reg[INT_TIMEOUT_BIT];
         end
      end
   end

   assign irq_o = timeout_flag_reg && irq_enable_reg;

   pin_sync3 u_aclk_sync (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .async_i(aclk_pin_i),
      .level_o(aclk_level)
   );

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aclk_prev_reg <= 1'b0;
      end else if (clk_en_i) begin
         aclk_prev_reg <= aclk_level;
      end
   end

   assign aclk_rise = aclk_level && !aclk_prev_reg;
   assign tick = clock_select_reg ? 1'b1 : aclk_rise;
   assign rate_p1 = {1'b0, rate_reg} + 17'h0_0001;
   // Bus clock doubles, autonomous clock quadruples (two per half period)
   assign term = clock_select_reg ? {1'b0, rate_p1, 1'b0} : {rate_p1, 2'b00};

   // Autonomous source waits for the gate to release before counting
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= T_IDLE;
         gate_cnt_reg <= '0;
      end else if (clk_en_i) begin
         unique case (state_reg)
            T_IDLE: begin
               gate_cnt_reg <= '0;
               if (feature_enable_reg) begin
                  state_reg <= clock_select_reg ? T_RUN : T_GATE;
               end
            end
            T_GATE: begin
               if (!feature_enable_reg) begin
                  state_reg <= T_IDLE;
               end else if (aclk_rise) begin
                  gate_cnt_reg <= gate_cnt_reg + 2'd1;
                  if (gate_cnt_reg == 2'(GATE_RELEASE_EDGES - 1)) begin
                     state_reg <= T_RUN;
                  end
               end
            end
            T_RUN: begin
               if (!feature_enable_reg) begin
                  state_reg <= T_IDLE;
               end
            end
            default: state_reg <= T_IDLE;
         endcase
      end
   end

   period_counter #(
      .WIDTH(CNT_W)
   ) u_period (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .clk_en_i(clk_en_i),
      .run_i(state_reg == T_RUN && feature_enable_reg),
      .tick_i(tick),
      .term_i(term),
      .timeout_o(timeout)
   );

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         periodic_timeout_o <= 1'b0;
      end else if (clk_en_i) begin
         periodic_timeout_o <= timeout;
      end
   end

   // Checking aid: ticks counted since run start or last timeout
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seen_reg <= '0;
      end else if (clk_en_i) begin
         if (state_reg != T_RUN || !feature_enable_reg) begin
            seen_reg <= '0;
         end else if (timeout) begin
            // Counter already takes a tick landing on the restart edge
            seen_reg <= tick ? CNT_W'(1) : '0;
         end else if (tick) begin
            seen_reg <= seen_reg + CNT_W'(1);
         end
      end
   end

   property p_rate_locked;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      feature_enable_reg |=> $stable(rate_reg);
   endproperty
   a_rate_locked: assert property (p_rate_locked) else $error("rate changed while enabled");

   property p_aclk_period;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (timeout && !clock_select_reg) |->
         ($past(seen_reg) + CNT_W'(1) == CNT_W'(4 * (int'(rate_reg) + 1)));
   endproperty
   a_aclk_period: assert property (p_aclk_period) else $error("autonomous period wrong");

   property p_bus_period;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (timeout && clock_select_reg) |->
         ($past(seen_reg) + CNT_W'(1) == CNT_W'(2 * (int'(rate_reg) + 1)));
   endproperty
   a_bus_period: assert property (p_bus_period) else $error("bus period wrong");

   property p_gate_latency;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && state_reg == T_IDLE && feature_enable_reg && !clock_select_reg)
         |=> (state_reg == T_GATE) ##1 !timeout;
   endproperty
   a_gate_latency: assert property (p_gate_latency) else $error("gate not applied");

   property p_test_guard;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (wr_test && !special_mode_i) |=> $stable(test_reg);
   endproperty
   a_test_guard: assert property (p_test_guard) else $error("test reg written outside mode");

   property p_nvm_load;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && load_pending_reg) |=>
         ({temp_oe_reg, 3'h0, temp_trim_reg} == ($past(nvm_temp_trim_i) & 8'h8F))
         && ({osc_high_reg, osc_low_reg} == $past(nvm_osc_trim_i));
   endproperty
   a_nvm_load: assert property (p_nvm_load) else $error("trim not loaded at release");

   property p_offset_gate;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      !temp_trim_o.offset_enable |-> (temp_trim_o.offset == 4'h0);
   endproperty
   a_offset_gate: assert property (p_offset_gate) else $error("offset active while disabled");

   property p_trim_protect;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (wr_osc && register_protect_i && !load_pending_reg) |=>
         $stable(osc_high_reg) && $stable(osc_low_reg);
   endproperty
   a_trim_protect: assert property (p_trim_protect) else $error("protected trim changed");

   property p_lock_clear;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && wr_osc && !register_protect_i && pll_clock_select_i) |=> lock_osc_clear_o;
   endproperty
   a_lock_clear: assert property (p_lock_clear) else $error("lock clear missing");

   property p_flag_set;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      (clk_en_i && timeout) |=> timeout_flag_reg ##0 (irq_o == irq_enable_reg);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("timeout flag not set");
endmodule

// ==== dv/tb_periodic_wakeup_top.sv ====
// Self-checking bench for the periodic wakeup timer and its trim registers.
// Assumes the design's AXI4-Lite slave, nonvolatile load at reset release and bus-clock timing.
`timescale 1ns/1ps
module tb_periodic_wakeup_top;
   import pwu_pkg::*;
   logic ref_clk_i = 0, reset_n_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ack = 0;
   logic spm = 0, register_protect = 0, pll = 0, irq, tmo, lck, awr, wr, bv, arr, rv;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd;
   logic [1:0] br, rr;
   temp_trim_s tt;
   osc_trim_s ot;
   int n_fail = 0, checks_done = 0, cyc = 0, n_lock = 0, n_tmo = 0, g, k;
   periodic_wakeup_top periodic_wakeup_top_inst (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
      .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .aclk_pin_i(ack), .special_mode_i(spm), .register_protect_i(register_protect),
      .pll_clock_select_i(pll), .nvm_temp_trim_i(8'h8A), .nvm_osc_trim_i(16'hA95C),
      .irq_o(irq), .periodic_timeout_o(tmo), .lock_osc_clear_o(lck),
      .temp_trim_o(tt), .osc_trim_o(ot));
   initial begin
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   // Slow autonomous clock, far below the filter's limit
   initial begin
      forever #800 ack = ~ack;
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (lck === 1'b1) n_lock++;
      if (tmo === 1'b1) n_tmo++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic a;
      logic w;
      a = 0;
      w = 0;
      @(posedge ref_clk_i);
      awa <= {idx, 2'b00};
      wd <= {24'h00_0000, d};
      awv <= 1;
      wv <= 1;
      bry <= 1;
      while (!(a && w)) begin
         @(posedge ref_clk_i);
         if (awr && !a) begin
            a = 1;
            awv <= 0;
         end
         if (wr && !w) begin
            w = 1;
            wv <= 0;
         end
      end
      do @(posedge ref_clk_i); while (bv !== 1'b1);
      bry <= 0;
      chk(br, er);
   endtask
   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
      @(posedge ref_clk_i);
      ara <= {idx, 2'b00};
      arv <= 1;
      rry <= 1;
      do @(posedge ref_clk_i); while (arr !== 1'b1);
      arv <= 0;
      do @(posedge ref_clk_i); while (rv !== 1'b1);
      rry <= 0;
      chk(rd, {24'h00_0000, exp});
      chk(rr, er);
   endtask
   // Cycles from one timeout pulse to the next
   task automatic gap(output int n);
      n = 0;
      do @(posedge ref_clk_i); while (tmo !== 1'b1);
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (tmo !== 1'b1);
   endtask
   task automatic t_load();
      rd_chk(IDX_TEMP_TRIM, 8'h8A, RESP_OKAY);
      rd_chk(IDX_OSC_TRIM_HIGH, 8'hA9, RESP_OKAY);
      rd_chk(IDX_OSC_TRIM_LOW, 8'h5C, RESP_OKAY);
      rd_chk(IDX_RATE_HIGH, 8'h00, RESP_OKAY);
      chk(tt, 32'h0000_001A);
      chk(ot, 32'h0000_D55C);
      $display("load test done");
   endtask
   task automatic t_trim();
      wr_reg(IDX_TEMP_TRIM, 8'h0A, RESP_OKAY);
      wr_reg(IDX_OSC_TRIM_HIGH, 8'h80, RESP_OKAY);
      repeat (2) @(posedge ref_clk_i);
      chk(tt, 32'h0000_0000);
      chk(ot, 32'h0000_405C);
      register_protect <= 1;
      pll <= 1;
      wr_reg(IDX_OSC_TRIM_LOW, 8'h33, RESP_OKAY);
      rd_chk(IDX_OSC_TRIM_LOW, 8'h5C, RESP_OKAY);
      chk(n_lock, 0);
      register_protect <= 0;
      wr_reg(IDX_OSC_TRIM_LOW, 8'h33, RESP_OKAY);
      rd_chk(IDX_OSC_TRIM_LOW, 8'h33, RESP_OKAY);
      chk(n_lock, 1);
      wr_reg(IDX_FACTORY_TEST, 8'h55, RESP_OKAY);
      rd_chk(IDX_FACTORY_TEST, 8'h00, RESP_OKAY);
      spm <= 1;
      wr_reg(IDX_FACTORY_TEST, 8'h55, RESP_OKAY);
      rd_chk(IDX_FACTORY_TEST, 8'h55, RESP_OKAY);
      wr_reg(6'h3F, 8'h11, RESP_SLVERR);
      rd_chk(6'h3F, 8'h00, RESP_SLVERR);
      $display("trim test done");
   endtask
   task automatic t_timer();
      wr_reg(IDX_RATE_HIGH, 8'h01, RESP_OKAY);
      wr_reg(IDX_RATE_LOW, 8'h02, RESP_OKAY);
      wr_reg(IDX_INT_MASK, 8'h01, RESP_OKAY);
      wr_reg(IDX_CTRL, 8'h80, RESP_OKAY);
      wr_reg(IDX_CTRL, 8'h84, RESP_OKAY);
      gap(g);
      chk(g, 518);
      gap(g);
      chk(g, 518);
      chk(irq, 1);
      wr_reg(IDX_RATE_LOW, 8'h07, RESP_OKAY);
      rd_chk(IDX_RATE_LOW, 8'h02, RESP_OKAY);
      wr_reg(IDX_CTRL, 8'h04, RESP_OKAY);
      rd_chk(IDX_CTRL, 8'h84, RESP_OKAY);
      wr_reg(IDX_CTRL, 8'h00, RESP_OKAY);
      repeat (3) @(posedge ref_clk_i);
      k = n_tmo;
      wr_reg(IDX_INT_STATUS, 8'h00, RESP_OKAY);
      rd_chk(IDX_INT_STATUS, 8'h01, RESP_OKAY);
      wr_reg(IDX_INT_STATUS, 8'h01, RESP_OKAY);
      rd_chk(IDX_INT_STATUS, 8'h00, RESP_OKAY);
      chk(irq, 0);
      repeat (600) @(posedge ref_clk_i);
      chk(n_tmo - k, 0);
      wr_reg(IDX_RATE_LOW, 8'h00, RESP_OKAY);
      wr_reg(IDX_RATE_HIGH, 8'h00, RESP_OKAY);
      wr_reg(IDX_CTRL, 8'h00, RESP_OKAY);
      wr_reg(IDX_CTRL, 8'h84, RESP_OKAY);
      rd_chk(IDX_CTRL, 8'h04, RESP_OKAY);
      gap(g);
      chk(g, 64);
      wr_reg(IDX_CTRL, 8'h00, RESP_OKAY);
      $display("timer test done");
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1;
      t_load();
      t_trim();
      t_timer();
      report_and_stop();
   end
endmodule
